// ### design/pwc_top.sv
// PWM time base, chop clock and one generator with AHB-Lite registers.
// Assumes inputs synchronous to clk and a zero-wait master.
//
// Functional notes
// R01: Unit idle, counters cleared, outputs low until global enable set.
// R02: Postscaler fires on every (code+1)th compare match.
// R03: Compare match when master count equals the compare register.
// R04: Software changes time base fields only while disabled.
// R05: With external sync, software sets period slightly longer.
// R06: Prescaler divides by 2**code, code 111 reserved.
// R07: Software changes prescaler only while disabled.
// R08: Period register 16 bits, resets to fff8.
// R09: Idle-stop bit halts time base during processor idle.
// R10: Gate clock generator with enable bit 15 and 10-bit divider.
// R11: Duty from master duty when select set, else own duty.
// R12: Flags set by hardware, cleared by software or enable clear.
// R13: Center alignment only with independent time base.
// R14: Current limit resets generator base when enabled and allowed.
// R15: Dead-time field decodes positive, negative, off, compensation.
// R16: Compensation polarity and input pick which output shortens.
// R17: Time base select picks secondary base when present.
// R18: Immediate update applies duty at once, else at boundary.
// R19: Software keeps generator mode bits fixed once enabled.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pwc_top (
  input  logic        clk,              // 50 MHz clock
  input  logic        reset,            // Sync reset, high
  input  logic        hsel,             // Slave select
  input  logic [31:0] haddr,            // Byte address
  input  logic [1:0]  htrans,           // Transfer type
  input  logic        hwrite,           // Write when high
  input  logic [2:0]  hsize,            // Word only
  input  logic [31:0] hwdata,           // Write data
  input  logic        hready,           // Bus ready
  output logic        hreadyout,        // Slave ready
  output logic        hresp,            // Always OKAY
  output logic [31:0] hrdata,           // Read data
  input  logic        idle_mode,        // Processor idle
  input  logic        fault_in,         // Fault event
  input  logic        current_limit_in, // Current limit
  input  logic        current_limit_mode, // Limit mode bit
  input  logic        compensation_input, // Comp sense
  input  logic        sec_present,      // Secondary base exists
  input  logic        sec_tick,         // Secondary count pulse
  input  logic        sec_boundary,     // Secondary period end
  output logic        pwm_high,         // High side drive
  output logic        pwm_low,          // Low side drive
  output logic        gate_clock,       // Chop clock
  output logic        special_trigger,  // Special event pulse
  output logic [3:0]  dead_mode,        // One-hot dead mode
  output logic        shorten_high,     // Comp shortens high
  output logic        shorten_low,      // Comp shortens low
  output logic        special_irq,      // Special event flag
  output logic        gen_irq           // Generator flags
);

  // ****************************************
  // Bus slave
  // ****************************************
  pwc_pkg::pwc_bus_type bus_r;
  pwc_pkg::pwc_bus_type bus_nxt;
  logic                 wr_r;
  logic                 wr_nxt;
  logic [7:0]           addr_r;
  logic [7:0]           addr_nxt;
  logic [31:0]          hrdata_r;
  logic [31:0]          hrdata_nxt;
  logic                 take;
  logic [15:0]          rd_val;
  logic [15:0]          wd;

  // Register state
  pwc_pkg::pwc_tbctl_type  tb_r;
  pwc_pkg::pwc_tbctl_type  tb_nxt;
  pwc_pkg::pwc_tbctl_type  tbw;
  pwc_pkg::pwc_genctl_type g_r;
  pwc_pkg::pwc_genctl_type g_nxt;
  pwc_pkg::pwc_genctl_type gw;
  logic [2:0]  presc_r;
  logic [2:0]  presc_nxt;
  logic [15:0] per_r;
  logic [15:0] per_nxt;
  logic [15:0] cmp_r;
  logic [15:0] cmp_nxt;
  logic [15:0] chop_r;
  logic [15:0] chop_nxt;
  logic [15:0] mdc_r;
  logic [15:0] mdc_nxt;
  logic [15:0] gduty_r;
  logic [15:0] gduty_nxt;
  logic [15:0] duty_act_r;
  logic [15:0] duty_act_nxt;

  // Time base and generator state
  logic        en;
  logic        run;
  logic        ptick;
  logic        tb_bnd;
  logic        match;
  logic        sp_trig;
  logic [15:0] tb_cnt_r;
  logic [15:0] tb_cnt_nxt;
  logic [9:0]  chop_cnt_r;
  logic [9:0]  chop_cnt_nxt;
  logic        gate_r;
  logic        gate_nxt;
  logic [15:0] gcnt_r;
  logic [15:0] gcnt_nxt;
  logic        gdown_r;
  logic        gdown_nxt;
  logic        center;
  logic        use_sec;
  logic        gtick;
  logic        gsync;
  logic        xrst;
  logic        gbnd;
  logic        pwm_h_r;
  logic        pwm_h_nxt;
  logic        pwm_l_r;
  logic        pwm_l_nxt;
  logic [3:0]  dead_r;
  logic [3:0]  dead_nxt;
  logic        sh_h_r;
  logic        sh_h_nxt;
  logic        sh_l_r;
  logic        sh_l_nxt;

  // Write strobe for one register
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_r && (addr_r == ofs);
  endfunction : hit

  assign take = hsel && htrans[1] && hready;
  assign wd   = hwdata[15:0];

  // Read mux
  always_comb
  begin
    rd_val = pwc_pkg::ZERO16;
    case (addr_r)
      pwc_pkg::OFS_TBCTL: rd_val = tb_r;
      pwc_pkg::OFS_PRESC: rd_val = {13'h0000, presc_r};
      pwc_pkg::OFS_PER:   rd_val = per_r;
      pwc_pkg::OFS_CMP:   rd_val = cmp_r;
      pwc_pkg::OFS_CHOP:  rd_val = chop_r;
      pwc_pkg::OFS_MDC:   rd_val = mdc_r;
      pwc_pkg::OFS_GCTL:  rd_val = g_r;
      pwc_pkg::OFS_GDUTY: rd_val = gduty_r;
      default:            rd_val = pwc_pkg::ZERO16;
    endcase
  end

  // Bus phase tracking; reads take one wait state
  always_comb
  begin
    bus_nxt    = bus_r;
    wr_nxt     = 1'b0;
    addr_nxt   = addr_r;
    hrdata_nxt = hrdata_r;
    unique case (bus_r)
      pwc_pkg::BUS_IDLE:
        if (take)
        begin
          addr_nxt = haddr[7:0];
          wr_nxt   = hwrite;
          if (!hwrite)
            bus_nxt = pwc_pkg::BUS_RDWAIT;
        end
      pwc_pkg::BUS_RDWAIT:
      begin
        hrdata_nxt = {16'h0000, rd_val};
        bus_nxt    = pwc_pkg::BUS_IDLE;
      end
      default: bus_nxt = pwc_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus_r    <= pwc_pkg::BUS_IDLE;
      wr_r     <= 1'b0;
      addr_r   <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      bus_r    <= bus_nxt;
      wr_r     <= wr_nxt;
      addr_r   <= addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hreadyout = (bus_r != pwc_pkg::BUS_RDWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ****************************************
  // Registers and flags
  // ****************************************
  assign tbw = pwc_pkg::pwc_tbctl_type'(wd);
  assign gw  = pwc_pkg::pwc_genctl_type'(wd);

  // Next register values; a hardware set beats a software clear
  always_comb
  begin
    tb_nxt    = tb_r;
    g_nxt     = g_r;
    presc_nxt = presc_r;
    per_nxt   = per_r;
    cmp_nxt   = cmp_r;
    chop_nxt  = chop_r;
    mdc_nxt   = mdc_r;
    gduty_nxt = gduty_r;
    if (hit(pwc_pkg::OFS_TBCTL))
      tb_nxt = pwc_pkg::pwc_tbctl_type'(wd & pwc_pkg::TBCTL_WMSK);
    if (hit(pwc_pkg::OFS_GCTL))
      g_nxt = pwc_pkg::pwc_genctl_type'(wd & pwc_pkg::GCTL_WMSK);
    if (hit(pwc_pkg::OFS_PRESC))
      presc_nxt = wd[2:0];
    if (hit(pwc_pkg::OFS_PER))
      per_nxt = wd;
    if (hit(pwc_pkg::OFS_CMP))
      cmp_nxt = wd;
    if (hit(pwc_pkg::OFS_CHOP))
      chop_nxt = wd & pwc_pkg::CHOP_WMSK;
    if (hit(pwc_pkg::OFS_MDC))
      mdc_nxt = wd;
    if (hit(pwc_pkg::OFS_GDUTY))
      gduty_nxt = wd;
    tb_nxt.special_flag = tb_nxt.special_irq_enable & (sp_trig |
      (hit(pwc_pkg::OFS_TBCTL) ? tb_r.special_flag & tbw.special_flag
                               : tb_r.special_flag));
    g_nxt.fault_flag = g_nxt.fault_irq_enable & (fault_in | // R12
      (hit(pwc_pkg::OFS_GCTL) ? g_r.fault_flag & gw.fault_flag
                              : g_r.fault_flag));
    g_nxt.current_limit_flag = g_nxt.current_limit_irq_enable & // R12
      (current_limit_in | (hit(pwc_pkg::OFS_GCTL)
        ? g_r.current_limit_flag & gw.current_limit_flag
        : g_r.current_limit_flag));
    g_nxt.trigger_flag = g_nxt.trigger_irq_enable & (gbnd | // R12
      (hit(pwc_pkg::OFS_GCTL) ? g_r.trigger_flag & gw.trigger_flag
                              : g_r.trigger_flag));
  end

  // Active duty: shared or own source, at once or at boundary
  always_comb
  begin
    duty_act_nxt = duty_act_r;
    if (!en || g_r.immediate_update_enable || gbnd) // R18
      duty_act_nxt = g_r.master_duty_select ? mdc_r : gduty_r; // R11
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tb_r       <= pwc_pkg::pwc_tbctl_type'(pwc_pkg::ZERO16);
      g_r        <= pwc_pkg::pwc_genctl_type'(pwc_pkg::ZERO16);
      presc_r    <= 3'h0;
      per_r      <= pwc_pkg::PER_RST; // R08
      cmp_r      <= pwc_pkg::ZERO16;
      chop_r     <= pwc_pkg::ZERO16;
      mdc_r      <= pwc_pkg::ZERO16;
      gduty_r    <= pwc_pkg::ZERO16;
      duty_act_r <= pwc_pkg::ZERO16;
    end
    else
    begin
      tb_r       <= tb_nxt;
      g_r        <= g_nxt;
      presc_r    <= presc_nxt;
      per_r      <= per_nxt;
      cmp_r      <= cmp_nxt;
      chop_r     <= chop_nxt;
      mdc_r      <= mdc_nxt;
      gduty_r    <= gduty_nxt;
      duty_act_r <= duty_act_nxt;
    end
  end

  assign special_irq = tb_r.special_flag;
  assign gen_irq     = g_r.fault_flag | g_r.current_limit_flag |
                       g_r.trigger_flag;

  // ****************************************
  // Master time base and chop clock
  // ****************************************
  assign en  = tb_r.unit_global_enable; // R01
  assign run = en && !(idle_mode && tb_r.idle_stop_select); // R09

  pwc_prescaler u_presc (
    .clk   (clk),
    .reset (reset),
    .clear (!en),
    .run   (run),
    .code  (presc_r),
    .tick  (ptick)
  );

  assign tb_bnd = ptick && (tb_cnt_r >= per_r);
  assign match  = ptick && (tb_cnt_r == cmp_r); // R03

  pwc_postscaler u_post (
    .clk   (clk),
    .reset (reset),
    .clear (!en),
    .match (match),
    .code  (tb_r.special_trigger_postscale),
    .trig  (sp_trig)
  );

  assign special_trigger = sp_trig;

  // Master count and gate clock divider
  always_comb
  begin
    tb_cnt_nxt   = tb_cnt_r;
    chop_cnt_nxt = chop_cnt_r;
    gate_nxt     = gate_r;
    if (!en) // R01
      tb_cnt_nxt = pwc_pkg::ZERO16;
    else if (ptick)
      tb_cnt_nxt = tb_bnd ? pwc_pkg::ZERO16 : tb_cnt_r + pwc_pkg::ONE16;
    if (!en || !chop_r[pwc_pkg::CHOP_EN]) // R10
    begin
      chop_cnt_nxt = 10'h000;
      gate_nxt     = 1'b0;
    end
    else if (ptick)
    begin
      if (chop_cnt_r == chop_r[9:0])
      begin
        chop_cnt_nxt = 10'h000;
        gate_nxt     = !gate_r;
      end
      else
        chop_cnt_nxt = chop_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tb_cnt_r   <= pwc_pkg::ZERO16;
      chop_cnt_r <= 10'h000;
      gate_r     <= 1'b0;
    end
    else
    begin
      tb_cnt_r   <= tb_cnt_nxt;
      chop_cnt_r <= chop_cnt_nxt;
      gate_r     <= gate_nxt;
    end
  end

  assign gate_clock = gate_r;

  // ****************************************
  // Generator
  // ****************************************
  assign center  = g_r.independent_time_base &
                   g_r.center_aligned_select; // R13
  assign use_sec = g_r.time_base_source_select & sec_present; // R17
  assign gtick   = use_sec ? (sec_tick && run) : ptick;
  assign gsync   = use_sec ? sec_boundary : tb_bnd;
  assign xrst    = run && g_r.external_period_reset && // R14
                   g_r.independent_time_base && !current_limit_mode &&
                   current_limit_in;
  assign gbnd    = g_r.independent_time_base
    ? gtick && (center ? gdown_r && gcnt_r == pwc_pkg::ZERO16
                       : gcnt_r >= per_r)
    : run && gsync;

  // Generator count, alignment and output decode
  always_comb
  begin
    gcnt_nxt  = gcnt_r;
    gdown_nxt = gdown_r & center;
    if (!en)
    begin
      gcnt_nxt  = pwc_pkg::ZERO16;
      gdown_nxt = 1'b0;
    end
    else if (!run)
      gcnt_nxt = gcnt_r;
    else if (xrst || (!g_r.independent_time_base && gsync))
    begin
      gcnt_nxt  = pwc_pkg::ZERO16;
      gdown_nxt = 1'b0;
    end
    else if (gtick)
    begin
      if (!center)
        gcnt_nxt = (gcnt_r >= per_r) ? pwc_pkg::ZERO16
                                     : gcnt_r + pwc_pkg::ONE16;
      else if (gdown_r)
      begin
        if (gcnt_r == pwc_pkg::ZERO16)
        begin
          gdown_nxt = 1'b0;
          gcnt_nxt  = pwc_pkg::ONE16;
        end
        else
          gcnt_nxt = gcnt_r - pwc_pkg::ONE16;
      end
      else if (gcnt_r >= per_r && gcnt_r != pwc_pkg::ZERO16)
      begin
        gdown_nxt = 1'b1;
        gcnt_nxt  = gcnt_r - pwc_pkg::ONE16;
      end
      else
        gcnt_nxt = gcnt_r + pwc_pkg::ONE16;
    end
    pwm_h_nxt = en && (gcnt_r < duty_act_r); // R01
    pwm_l_nxt = en && !(gcnt_r < duty_act_r);
    dead_nxt  = pwc_pkg::DT_POSITIVE;
    unique case (g_r.dead_time_mode) // R15
      pwc_pkg::DTC_POS:  dead_nxt = pwc_pkg::DT_POSITIVE;
      pwc_pkg::DTC_NEG:  dead_nxt = pwc_pkg::DT_NEGATIVE;
      pwc_pkg::DTC_OFF:  dead_nxt = pwc_pkg::DT_DISABLED;
      pwc_pkg::DTC_COMP: dead_nxt = pwc_pkg::DT_COMPENSATE;
    endcase
    sh_l_nxt = (g_r.dead_time_mode == pwc_pkg::DTC_COMP) && // R16
               (g_r.compensation_polarity ^ compensation_input);
    sh_h_nxt = (g_r.dead_time_mode == pwc_pkg::DTC_COMP) &&
               !(g_r.compensation_polarity ^ compensation_input);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gcnt_r  <= pwc_pkg::ZERO16;
      gdown_r <= 1'b0;
      pwm_h_r <= 1'b0;
      pwm_l_r <= 1'b0;
      dead_r  <= pwc_pkg::DT_POSITIVE;
      sh_h_r  <= 1'b0;
      sh_l_r  <= 1'b0;
    end
    else
    begin
      gcnt_r  <= gcnt_nxt;
      gdown_r <= gdown_nxt;
      pwm_h_r <= pwm_h_nxt;
      pwm_l_r <= pwm_l_nxt;
      dead_r  <= dead_nxt;
      sh_h_r  <= sh_h_nxt;
      sh_l_r  <= sh_l_nxt;
    end
  end

  assign pwm_high     = pwm_h_r;
  assign pwm_low      = pwm_l_r;
  assign dead_mode    = dead_r;
  assign shorten_high = sh_h_r;
  assign shorten_low  = sh_l_r;

  // ****************************************
  // Checks
  // ****************************************
  idle_clear_a: assert property ( // R01
    @(posedge clk) disable iff (reset)
    !en |=> tb_cnt_r == 16'h0000 && !pwm_high && !pwm_low)
    else $error("unit active while disabled");

  cmp_trig_a: assert property ( // R03
    @(posedge clk) disable iff (reset)
    en && ptick && tb_cnt_r == cmp_r &&
    tb_r.special_trigger_postscale == 4'h0 |=> special_trigger)
    else $error("compare match gave no trigger");

  period_rst_a: assert property ( // R08
    @(posedge clk)
    reset |=> per_r == 16'hfff8)
    else $error("period reset value wrong");

  idle_halt_a: assert property ( // R09
    @(posedge clk) disable iff (reset)
    en && idle_mode && tb_r.idle_stop_select |=> $stable(tb_cnt_r))
    else $error("time base moved during idle stop");

  chop_off_a: assert property ( // R10
    @(posedge clk) disable iff (reset)
    !chop_r[15] |=> !gate_clock)
    else $error("gate clock runs while off");

  duty_mdc_a: assert property ( // R11
    @(posedge clk) disable iff (reset)
    en && g_r.immediate_update_enable && g_r.master_duty_select
    |=> duty_act_r == $past(mdc_r))
    else $error("shared duty not applied");

  duty_hold_a: assert property ( // R18
    @(posedge clk) disable iff (reset)
    en && !g_r.immediate_update_enable && !gbnd |=> $stable(duty_act_r))
    else $error("duty changed off boundary");

  flag_gate_a: assert property ( // R12
    @(posedge clk) disable iff (reset)
    !g_r.fault_irq_enable |-> !g_r.fault_flag)
    else $error("fault flag set while disabled");

  center_a: assert property ( // R13
    @(posedge clk) disable iff (reset)
    !center |=> !gdown_r)
    else $error("down count outside center mode");

  xres_a: assert property ( // R14
    @(posedge clk) disable iff (reset)
    xrst |=> gcnt_r == 16'h0000)
    else $error("external reset ignored");

  comp_a: assert property ( // R16
    @(posedge clk) disable iff (reset)
    g_r.dead_time_mode == 2'h3 && g_r.compensation_polarity &&
    !compensation_input |=> shorten_low && !shorten_high)
    else $error("compensation direction wrong");

endmodule : pwc_top

// ### shared/pwc_pkg.sv
// Constants, register layouts and types for the pwm control block.
// Assumes a single 50 MHz clock and an AHB-Lite register port.
package pwc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_TBCTL = 8'h00;
  localparam logic [7:0] OFS_PRESC = 8'h04;
  localparam logic [7:0] OFS_PER   = 8'h08;
  localparam logic [7:0] OFS_CMP   = 8'h0c;
  localparam logic [7:0] OFS_CHOP  = 8'h10;
  localparam logic [7:0] OFS_MDC   = 8'h14;
  localparam logic [7:0] OFS_GCTL  = 8'h18;
  localparam logic [7:0] OFS_GDUTY = 8'h1c;

  // ****************************************
  // Reset values and write masks
  // ****************************************
  localparam logic [15:0] PER_RST    = 16'hfff8;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [15:0] ONE16      = 16'h0001;
  localparam logic [15:0] TBCTL_WMSK = 16'hbfff;
  localparam logic [15:0] GCTL_WMSK  = 16'hffef;
  localparam logic [15:0] CHOP_WMSK  = 16'h83ff;
  localparam logic [2:0]  PRESC_RSVD = 3'h7;
  localparam int          CHOP_EN    = 15;

  // Dead-time control codes
  localparam logic [1:0] DTC_POS  = 2'h0;
  localparam logic [1:0] DTC_NEG  = 2'h1;
  localparam logic [1:0] DTC_OFF  = 2'h2;
  localparam logic [1:0] DTC_COMP = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    DT_POSITIVE   = 4'b0001,
    DT_NEGATIVE   = 4'b0010,
    DT_DISABLED   = 4'b0100,
    DT_COMPENSATE = 4'b1000
  } pwc_dead_type;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_RDWAIT = 2'b10
  } pwc_bus_type;

  typedef struct packed {
    logic       unit_global_enable;
    logic       rsvd;
    logic       idle_stop_select;
    logic       special_flag;
    logic       special_irq_enable;
    logic [6:0] sync_fields;
    logic [3:0] special_trigger_postscale;
  } pwc_tbctl_type;

  typedef struct packed {
    logic       fault_flag;
    logic       current_limit_flag;
    logic       trigger_flag;
    logic       fault_irq_enable;
    logic       current_limit_irq_enable;
    logic       trigger_irq_enable;
    logic       independent_time_base;
    logic       master_duty_select;
    logic [1:0] dead_time_mode;
    logic       compensation_polarity;
    logic       rsvd;
    logic       time_base_source_select;
    logic       center_aligned_select;
    logic       external_period_reset;
    logic       immediate_update_enable;
  } pwc_genctl_type;

  // Terminal count of the prescaler for a divide code
  function automatic logic [5:0] presc_limit(input logic [2:0] code);
    presc_limit = 6'((7'h01 << code) - 7'h01);
  endfunction : presc_limit

endpackage : pwc_pkg

// ### design/pwc_prescaler.sv
// Input clock prescaler: one-cycle tick every 2**code clocks.
// Assumes clear while the unit is disabled and run gating idle.
`timescale 1ns/1ps
module pwc_prescaler (
  input  logic       clk,   // System clock
  input  logic       reset, // Sync reset, high
  input  logic       clear, // Restart count
  input  logic       run,   // Count enable
  input  logic [2:0] code,  // Divide select
  output logic       tick   // Prescaled pulse
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  // Tick at terminal count, never for the reserved code
  assign tick = run && (code != pwc_pkg::PRESC_RSVD) &&
                (cnt_r == pwc_pkg::presc_limit(code)); // R06

  // Next count
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (clear || tick)
      cnt_nxt = 6'h00;
    else if (run)
      cnt_nxt = cnt_r + 6'h01;
  end

  // Count register
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= 6'h00;
    else
      cnt_r <= cnt_nxt;
  end

  presc_gap_a: assert property ( // R06
    @(posedge clk) disable iff (reset)
    tick && code != 3'h0 |=> !tick)
    else $error("prescaler ticked twice in a row");

endmodule : pwc_prescaler

// ### design/pwc_postscaler.sv
// Special event postscaler: one trigger per (code+1) matches.
// Assumes match is a one-cycle pulse.
`timescale 1ns/1ps
module pwc_postscaler (
  input  logic       clk,   // System clock
  input  logic       reset, // Sync reset, high
  input  logic       clear, // Restart count
  input  logic       match, // Compare match
  input  logic [3:0] code,  // Postscale select
  output logic       trig   // Trigger pulse
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       trig_r;
  logic       trig_nxt;

  // Count matches, fire on the last one of a group
  always_comb
  begin
    cnt_nxt  = cnt_r;
    trig_nxt = 1'b0;
    if (clear)
      cnt_nxt = 4'h0;
    else if (match)
    begin
      if (cnt_r >= code) // R02
      begin
        cnt_nxt  = 4'h0;
        trig_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 4'h1;
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r  <= 4'h0;
      trig_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      trig_r <= trig_nxt;
    end
  end

  assign trig = trig_r;

  post_fire_a: assert property ( // R02
    @(posedge clk) disable iff (reset)
    match && !clear && cnt_r >= code |=> trig)
    else $error("postscaler missed its trigger");

  post_quiet_a: assert property ( // R02
    @(posedge clk) disable iff (reset)
    !match |=> !trig)
    else $error("trigger without a match");

endmodule : pwc_postscaler

// ### testbench/pwc_stage_model.sv
// Power stage stand-in: counts special trigger pulses.
// Assumes the trigger is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module pwc_stage_model (
  input  wire logic clk,   // System clock
  input  wire logic trig,  // Converter trigger
  output int        count  // Triggers seen
);
  // One count per trigger cycle
  initial count = 0;
  always @(posedge clk)
    if (trig === 1'b1)
      count <= count + 1;
endmodule : pwc_stage_model

// ### testbench/tb_pwm_time_base_and_generator_control.sv
// Bench for the pwm control block: AHB-Lite register tasks, timing tests.
// Assumes a zero-wait write and a one-wait read from the slave.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module tb_pwm_time_base_and_generator_control;
  logic        clk = 0, reset = 1, hsel = 0, hwrite = 0, zero = 0;
  logic        idle_mode = 0, fault_in = 0, comp_in = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  wire         hreadyout, special_trigger, gen_irq, special_irq, hresp;
  wire         pwm_high, pwm_low, gate_clock, shorten_high, shorten_low;
  wire  [3:0]  dead_mode;
  int          fails = 0, samples_checked = 0, seen, n, n0, i;
  int          pss[5] = '{0, 1, 15, 0, 3};
  int          pcs[5] = '{0, 0, 0, 2, 6};

  pwc_top pwc_top_inst (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
    .fault_in(fault_in), .current_limit_in(zero), .current_limit_mode(zero),
    .compensation_input(comp_in), .sec_present(zero), .sec_tick(zero),
    .sec_boundary(zero), .pwm_high(pwm_high), .pwm_low(pwm_low),
    .gate_clock(gate_clock), .special_trigger(special_trigger),
    .dead_mode(dead_mode), .shorten_high(shorten_high),
    .shorten_low(shorten_low), .special_irq(special_irq),
    .gen_irq(gen_irq));
  pwc_stage_model pwc_stage_model_inst (.clk(clk),
    .trig(special_trigger), .count(seen));

  initial forever #10 clk = ~clk;

  // One single AHB transfer, read data taken at the final edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  // Clocks between two successive special triggers
  task automatic gap();
    n = 0;
    do @(posedge clk); while (special_trigger !== 1'b1);
    do
    begin
      @(posedge clk);
      n++;
    end while (special_trigger !== 1'b1);
  endtask : gap

  // High-side and gate clock on-cycles over eight clocks
  task automatic on_count();
    n = 0;
    n0 = 0;
    repeat (8) @(posedge clk);
    repeat (8)
    begin
      @(posedge clk);
      n += int'(pwm_high);
      n0 += int'(gate_clock);
      `CHK(pwm_high ^ pwm_low, 1'b1)
    end
  endtask : on_count

  task automatic summarize();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // Watchdog against a hung handshake
  initial
  begin
    #400000;
    fails++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    xfer(0, pwc_pkg::OFS_PER, 0);
    `CHK(q, 32'h0000_fff8)
    `CHK(hresp, 1'b0)
    xfer(0, 8'h20, 16'hffff);
    `CHK(q, 32'h0000_0000)
    xfer(1, pwc_pkg::OFS_CHOP, 16'hffff);
    xfer(0, pwc_pkg::OFS_CHOP, 0);
    `CHK(q, 32'h0000_83ff)
    xfer(1, pwc_pkg::OFS_PER, 16'h0003);
    n0 = seen;
    repeat (40) @(posedge clk);
    `CHK(seen, n0)
    // Postscale and prescale codes, changed only while disabled
    for (i = 0; i < 5; i++)
    begin
      xfer(1, pwc_pkg::OFS_TBCTL, 0);
      xfer(1, pwc_pkg::OFS_PRESC, 16'(pcs[i]));
      xfer(1, pwc_pkg::OFS_TBCTL, 16'h8000 | 16'(pss[i]));
      gap();
      `CHK(n, (4 * (pss[i] + 1)) << pcs[i])
    end
    xfer(1, pwc_pkg::OFS_TBCTL, 0);
    xfer(1, pwc_pkg::OFS_PRESC, 0);
    xfer(1, pwc_pkg::OFS_TBCTL, 16'ha800);
    idle_mode <= 1'b1;
    n0 = seen;
    repeat (40) @(posedge clk);
    `CHK(seen, n0)
    idle_mode <= 1'b0;
    gap();
    `CHK(n, 4)
    `CHK(special_irq, 1'b1)
    xfer(1, pwc_pkg::OFS_CMP, 16'h0005);
    n0 = seen;
    repeat (40) @(posedge clk);
    `CHK(seen, n0)
    xfer(1, pwc_pkg::OFS_GCTL, 16'h1000);
    fault_in <= 1'b1;
    @(posedge clk);
    fault_in <= 1'b0;
    xfer(0, pwc_pkg::OFS_GCTL, 0);
    `CHK(q, 32'h0000_9000)
    xfer(1, pwc_pkg::OFS_GCTL, 0);
    repeat (2) @(posedge clk);
    `CHK(gen_irq, 1'b0)
    // Dead-time decode and compensation direction
    xfer(1, pwc_pkg::OFS_GCTL, 16'h00e0);
    repeat (2) @(posedge clk);
    `CHK(dead_mode, 4'b1000)
    `CHK({shorten_high, shorten_low}, 2'b01)
    comp_in <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({shorten_high, shorten_low}, 2'b10)
    xfer(1, pwc_pkg::OFS_GCTL, 16'h0080);
    repeat (2) @(posedge clk);
    `CHK(dead_mode, 4'b0100)
    `CHK({shorten_high, shorten_low}, 2'b00)
    // Own duty at the boundary, then shared duty and chop clock
    xfer(1, pwc_pkg::OFS_GDUTY, 16'h0002);
    on_count();
    `CHK(n, 4)
    xfer(1, pwc_pkg::OFS_TBCTL, 0);
    xfer(1, pwc_pkg::OFS_MDC, 16'h0001);
    xfer(1, pwc_pkg::OFS_CHOP, 16'h8001);
    xfer(1, pwc_pkg::OFS_GCTL, 16'h0100);
    `CHK(pwm_high, 1'b0)
    xfer(1, pwc_pkg::OFS_TBCTL, 16'h8000);
    on_count();
    `CHK(n, 2)
    `CHK(n0, 4)
    summarize();
  end
endmodule : tb_pwm_time_base_and_generator_control
